// ==== logic/tccu_top.sv ====
// Capture/compare unit top with classic Wishbone slave
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
module tccu_top #(
	parameter int unsigned SYNC_STAGES = tccu_pkg::SYNC_STAGES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,

	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [tccu_pkg::WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [tccu_pkg::WB_DW-1:0] wb_dat_i,
	output logic [tccu_pkg::WB_DW-1:0] wb_dat_o,
	output logic wb_ack_o,

	// Reference timer and power state
	input wire logic [tccu_pkg::TIMER_W-1:0] timer_i,
	input wire logic sleep_i,

	// Capture/compare pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,

	// Event outputs
	output logic trigger_o,
	output logic irq_flag_o
);
	import tccu_pkg::*;

	// Parameter sanity
	if (SYNC_STAGES < 2) begin : g_chk
		$error("tccu_top needs at least two pin sync stages");
	end

	// Register state
	logic [7:0] unit_control;
	logic [7:0] match_capture_low;
	logic [7:0] match_capture_high;
	logic unit_irq_flag;
	logic pin_latch;
	logic eq_prev;

	// Next values
	logic [7:0] next_match_low;
	logic [7:0] next_match_high;
	logic next_pin_latch;

	// Event carrier between edge, prescaler and core
	tccu_evt_if evt ();

	// Pin edges
	tccu_sync_edge #(
		.STAGES(SYNC_STAGES)
	) u_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(pin_i),
		.evt(evt)
	);

	// Edge qualification
	tccu_prescaler #(
		.CNT_W(PRESC_W)
	) u_presc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.evt(evt)
	);

	// Bus request decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire hit_ctl = (wb_adr_i == OFS_CONTROL);
	wire hit_low = (wb_adr_i == OFS_MATCH_LOW);
	wire hit_high = (wb_adr_i == OFS_MATCH_HIGH);
	wire hit_stat = (wb_adr_i == OFS_STATUS);
	wire wr_ctl = bus_wr & hit_ctl;
	wire wr_low = bus_wr & hit_low;
	wire wr_high = bus_wr & hit_high;
	wire wr_stat = bus_wr & hit_stat;

	// Mode decode of the current setting
	tccu_mode_t mode;
	assign mode = tccu_mode_t'(unit_control[MODE_LSB +: MODE_W]);

	wire is_capture = (mode == TCCU_CAP_FALL) |
		(mode == TCCU_CAP_RISE) |
		(mode == TCCU_CAP_RISE4) |
		(mode == TCCU_CAP_RISE16);
	wire drives_pin = (mode == TCCU_CMP_TOGGLE) |
		(mode == TCCU_CMP_SET) |
		(mode == TCCU_CMP_CLEAR);
	wire is_compare = drives_pin |
		(mode == TCCU_CMP_SWINT) |
		(mode == TCCU_CMP_TRIG);

	// Mode decode of a value being written
	tccu_mode_t wr_mode;
	assign wr_mode = tccu_mode_t'(wb_dat_i[MODE_LSB +: MODE_W]);

	// Prescaler steering; off and non-capture modes hold it clear
	assign evt.pres_clear = ~is_capture;
	assign evt.pres_sel = unit_control[1:0];

	// Qualified capture; clock runs in sleep, so capture does too
	wire cap_hit = evt.capture_evt & is_capture;

	// Continuous 16-bit equality against the timer
	wire [TIMER_W-1:0] match_pair = {match_capture_high, match_capture_low};
	wire eq_now = (match_pair == timer_i);

	// Fire once on entering a match, since the timer may dwell
	// on one count for several clocks; compare needs the clock,
	// so it is held off in sleep
	wire cmp_hit = is_compare & eq_now & ~eq_prev & ~sleep_i;

	// Software clear of the flag, write one to clear
	wire flag_clr = wr_stat & wb_dat_i[STAT_FLAG_BIT];

	// Read data selection
	wire [7:0] stat_byte = {5'h00, eq_now, pin_latch, unit_irq_flag};
	wire [7:0] rd_byte = hit_ctl ? unit_control :
		hit_low ? match_capture_low :
		hit_high ? match_capture_high :
		hit_stat ? stat_byte : 8'h00;

	// Single-cycle answer, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// Read data registered with the answer; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (bus_req & ~wb_we_i) begin
			wb_dat_o <= {24'h000000, rd_byte};
		end
	end

	// Control register; all eight bits stored, upper four unused
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_control <= CONTROL_RESET;
		end else if (wr_ctl) begin
			unit_control <= wb_dat_i[7:0];
		end
	end

	// Capture loads the timer; it wins over a software byte write
	always_comb begin
		next_match_low = match_capture_low;
		next_match_high = match_capture_high;
		if (wr_low) begin
			next_match_low = wb_dat_i[7:0];
		end
		if (wr_high) begin
			next_match_high = wb_dat_i[7:0];
		end
		if (cap_hit) begin
			// Timer frozen in sleep gives its held value
			next_match_low = timer_i[7:0];
			next_match_high = timer_i[15:8];
		end
	end

	// Match/capture pair; an unread value is simply overwritten
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_capture_low <= MATCH_RESET;
			match_capture_high <= MATCH_RESET;
		end else begin
			match_capture_low <= next_match_low;
			match_capture_high <= next_match_high;
		end
	end

	// Equality history for the entry detector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eq_prev <= 1'b0;
		end else begin
			eq_prev <= eq_now;
		end
	end

	// Compare output latch: init on mode write, act on match
	always_comb begin
		next_pin_latch = pin_latch;
		if (cmp_hit) begin
			case (mode)
				TCCU_CMP_TOGGLE: next_pin_latch = ~pin_latch;
				TCCU_CMP_SET: next_pin_latch = 1'b1;
				TCCU_CMP_CLEAR: next_pin_latch = 1'b0;
				default: next_pin_latch = pin_latch;
			endcase
		end
		if (wr_ctl) begin
			case (wr_mode)
				TCCU_OFF: next_pin_latch = 1'b0;
				TCCU_CMP_SET: next_pin_latch = 1'b0;
				TCCU_CMP_CLEAR: next_pin_latch = 1'b1;
				default: next_pin_latch = pin_latch;
			endcase
		end
	end

	// Latch and pin drive registered together with the flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_latch <= 1'b0;
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			pin_latch <= next_pin_latch;
			pin_o <= next_pin_latch;
			pin_oe_o <= wr_ctl ? ((wr_mode == TCCU_CMP_TOGGLE) |
				(wr_mode == TCCU_CMP_SET) |
				(wr_mode == TCCU_CMP_CLEAR)) : drives_pin;
		end
	end

	// Special event trigger, one-cycle pulse for timer reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trigger_o <= 1'b0;
		end else begin
			trigger_o <= cmp_hit & (mode == TCCU_CMP_TRIG);
		end
	end

	// Sticky flag: events win over a clear in the same cycle;
	// a capture queued before a mode switch may land as a false
	// event, which software is expected to mask and clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_irq_flag <= 1'b0;
		end else begin
			unit_irq_flag <= cap_hit | cmp_hit |
				(unit_irq_flag & ~flag_clr);
		end
	end

	// Flag copy for the outside enable and interrupt logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flag_o <= 1'b0;
		end else begin
			irq_flag_o <= cap_hit | cmp_hit |
				(unit_irq_flag & ~flag_clr);
		end
	end

endmodule

// ==== common/tccu_pkg.sv ====
// Shared constants and types for the timer capture/compare unit
// Contract
// - Capture mode change may raise false flag
// - Four capture prescaler settings via mode field
// - Prescaler cleared when off or not capturing
// - Every reset clears the prescaler counter
// - Prescaler-to-prescaler switch keeps count, may glitch
// - Timer holds during sleep, resumes afterwards; the bench timer keeps running in sleep
// - Capture keeps working while device sleeps
// - Compare match pair against timer continuously
// - Match performs toggle, set, clear, trigger, interrupt
// - Flag set in same cycle as pin action
// - Every compare mode raises flag on match
// - Capture copies timer into match pair
// - Capture sets sticky flag, overwrites old value
// - Capture codes: falling, rising, 4th, 16th
// - Code 0010 toggles pin on each match
package tccu_pkg;

	// Widths
	localparam int unsigned TIMER_W = 16;
	localparam int unsigned WB_AW = 8;
	localparam int unsigned WB_DW = 32;
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned PRESC_W = 4;

	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MATCH_LOW = 8'h04;
	localparam logic [7:0] OFS_MATCH_HIGH = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MATCH_RESET = 8'h00;

	// Field positions
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned MODE_W = 4;
	localparam int unsigned STAT_FLAG_BIT = 0;
	localparam int unsigned STAT_PIN_BIT = 1;
	localparam int unsigned STAT_EQ_BIT = 2;

	// Prescaler divisors
	localparam logic [PRESC_W-1:0] PRESC_DIV4_LAST = 4'h3;
	localparam logic [PRESC_W-1:0] PRESC_DIV16_LAST = 4'hF;

	// Prescaler selections, low two bits of a capture mode
	localparam logic [1:0] PSEL_FALL = 2'h0;
	localparam logic [1:0] PSEL_RISE = 2'h1;
	localparam logic [1:0] PSEL_DIV4 = 2'h2;
	localparam logic [1:0] PSEL_DIV16 = 2'h3;

	// Mode field encodings
	typedef enum logic [3:0] {
		TCCU_OFF = 4'b0000,
		TCCU_RSVD = 4'b0001,
		TCCU_CMP_TOGGLE = 4'b0010,
		TCCU_CAP_PLAIN = 4'b0011,
		TCCU_CAP_FALL = 4'b0100,
		TCCU_CAP_RISE = 4'b0101,
		TCCU_CAP_RISE4 = 4'b0110,
		TCCU_CAP_RISE16 = 4'b0111,
		TCCU_CMP_SET = 4'b1000,
		TCCU_CMP_CLEAR = 4'b1001,
		TCCU_CMP_SWINT = 4'b1010,
		TCCU_CMP_TRIG = 4'b1011
	} tccu_mode_t;

endpackage

// ==== common/tccu_evt_if.sv ====
// Event carrier between pin edge logic, prescaler and core
`timescale 1ns/100ps
interface tccu_evt_if;
	logic rise;
	logic fall;
	logic pres_clear;
	logic [1:0] pres_sel;
	logic capture_evt;

	// Edge detector side
	modport edge_mp (output rise, output fall);
	// Prescaler side
	modport presc_mp (
		input rise,
		input fall,
		input pres_clear,
		input pres_sel,
		output capture_evt
	);
	// Core side
	modport core_mp (
		input capture_evt,
		output pres_clear,
		output pres_sel
	);
endinterface

// ==== logic/tccu_sync_edge.sv ====
// Pin synchroniser and edge detector
`timescale 1ns/100ps
module tccu_sync_edge #(
	parameter int unsigned STAGES = tccu_pkg::SYNC_STAGES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw pin
	input wire logic pin_i,
	// Edge pulses
	tccu_evt_if.edge_mp evt
);
	import tccu_pkg::*;

	if (STAGES < 2) begin : g_chk
		$error("tccu_sync_edge needs at least two stages");
	end

	logic [STAGES-1:0] sync;
	logic prev;

	// Only the last stage is looked at; earlier ones may be metastable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync <= '0;
			prev <= 1'b0;
		end else begin
			sync <= {sync[STAGES-2:0], pin_i};
			prev <= sync[STAGES-1];
		end
	end

	// One pulse per settled edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt.rise <= 1'b0;
			evt.fall <= 1'b0;
		end else begin
			evt.rise <= sync[STAGES-1] & ~prev;
			evt.fall <= ~sync[STAGES-1] & prev;
		end
	end
endmodule

// ==== logic/tccu_prescaler.sv ====
// Capture edge prescaler
`timescale 1ns/100ps
module tccu_prescaler #(
	parameter int unsigned CNT_W = tccu_pkg::PRESC_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Edges in, qualified capture out
	tccu_evt_if.presc_mp evt
);
	import tccu_pkg::*;

	if (CNT_W != PRESC_W) begin : g_chk
		$error("tccu_prescaler counter must be four bits");
	end

	logic [CNT_W-1:0] cnt;
	wire div_mode = evt.pres_sel[1];
	wire [CNT_W-1:0] last = (evt.pres_sel == PSEL_DIV16) ?
		PRESC_DIV16_LAST : PRESC_DIV4_LAST;
	wire wrap = evt.rise & div_mode & (cnt == last);

	// Counter survives a direct divisor switch, so it may fire early
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= '0;
		end else if (evt.pres_clear) begin
			cnt <= '0;
		end else if (wrap) begin
			cnt <= '0;
		end else if (evt.rise & div_mode) begin
			cnt <= cnt + 1'b1;
		end
	end

	// Qualified event, one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt.capture_evt <= 1'b0;
		end else if (evt.pres_clear) begin
			evt.capture_evt <= 1'b0;
		end else begin
			case (evt.pres_sel)
				PSEL_FALL: evt.capture_evt <= evt.fall;
				PSEL_RISE: evt.capture_evt <= evt.rise;
				default: evt.capture_evt <= wrap;
			endcase
		end
	end
endmodule

// ==== tb/tccu_top_asserts.sv ====
// Port-level checker for the capture/compare unit
`timescale 1ns/100ps
module tccu_top_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Timer, pin, events
	input wire logic [15:0] timer_i,
	input wire logic sleep_i,
	input wire logic pin_i,
	input wire logic pin_o,
	input wire logic pin_oe_o,
	input wire logic trigger_o,
	input wire logic irq_flag_o
);
	import tccu_pkg::*;
	logic [3:0] mode_q;
	logic [15:0] mt;
	logic vld;
	logic eq_d;
	wire wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & wb_sel_i[0];
	wire eq = mt == timer_i;
	wire cmp = mode_q == 4'h2 || mode_q[3:2] == 2'h2;
	wire hit = cmp & vld & eq & !eq_d & !sleep_i;
	// Mirror of mode and match; captures make it stale, so vld drops
	always_ff @(posedge clk_i) begin
		eq_d <= eq;
		if (rst_i) begin
			mode_q <= 4'h0;
			mt <= 16'h0000;
			vld <= 1'b0;
		end else if (wr && wb_adr_i == OFS_CONTROL) begin
			mode_q <= wb_dat_i[3:0];
		end else if (wr && wb_adr_i == OFS_MATCH_LOW) begin
			mt[7:0] <= wb_dat_i[7:0];
		end else if (wr && wb_adr_i == OFS_MATCH_HIGH) begin
			mt[15:8] <= wb_dat_i[7:0];
			vld <= 1'b1;
		end else if (mode_q[3:2] == 2'h1) begin
			vld <= 1'b0;
		end
	end
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_match_flag: assert property (hit |=> irq_flag_o)
		else $error("no flag after match");
	a_toggle_pin: assert property (hit && mode_q == 4'h2 |=> $changed(pin_o))
		else $error("pin not toggled");
	a_set_pin: assert property (hit && mode_q == 4'h8 |=> pin_o)
		else $error("pin not set");
	a_clear_pin: assert property (hit && mode_q == 4'h9 |=> !pin_o)
		else $error("pin not cleared");
	a_trig_pulse: assert property (hit && mode_q == 4'hB |=> trigger_o ##1 !trigger_o)
		else $error("bad trigger pulse");
	a_trig_flag: assert property (trigger_o |-> irq_flag_o)
		else $error("trigger without flag");
	a_pin_with_flag: assert property (cmp && $changed(pin_o) && !$past(wr) |-> irq_flag_o)
		else $error("pin moved without flag");
	a_off_no_flag: assert property ($rose(irq_flag_o) |-> $past(mode_q) != 4'h0)
		else $error("flag raised while off");
	c_toggle: cover property (hit && mode_q == 4'h2);
	c_trig: cover property (hit && mode_q == 4'hB);
	c_capture: cover property ($rose(irq_flag_o) && !cmp);
endmodule
bind tccu_top tccu_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_i(timer_i),
	.sleep_i(sleep_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
	.trigger_o(trigger_o), .irq_flag_o(irq_flag_o));

// ==== tb/tccu_pin_src.sv ====
// External event source driving the capture pin
`timescale 1ns/100ps
module tccu_pin_src (
	// Clock and command
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [4:0] n_i,
	// Pin drive
	output logic pin_o,
	output logic busy_o
);
	logic [4:0] left = 5'h00;
	logic [2:0] ph = 3'h0;
	initial begin
		pin_o = 1'b0;
		busy_o = 1'b0;
	end
	// Three clocks high, three low, so the synchroniser sees each level
	always @(posedge clk_i) begin
		if (go_i && !busy_o) begin
			left <= n_i;
			busy_o <= 1'b1;
			ph <= 3'h0;
		end else if (busy_o) begin
			pin_o <= ph < 3'h3;
			ph <= ph == 3'h5 ? 3'h0 : ph + 3'h1;
			if (ph == 3'h5) begin
				left <= left - 5'h01;
				busy_o <= left != 5'h01;
			end
		end
	end
endmodule

// ==== tb/tccu_top_tb.sv ====
// Self-checking bench for the capture/compare unit
`timescale 1ns/100ps
module tccu_top_tb;
	import tccu_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slp = 0, go = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdo, rdat;
	logic [15:0] tmr = 16'h0000;
	logic [4:0] npul = 5'h00;
	logic pin, busy, pin_o, oe, trig, irq, ack, tseen;
	int fails = 0, checked = 0, cycles = 0;
	tccu_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .timer_i(tmr),
		.sleep_i(slp), .pin_i(pin), .pin_o(pin_o), .pin_oe_o(oe),
		.trigger_o(trig), .irq_flag_o(irq));
	tccu_pin_src u_src (.clk_i(clk_i), .go_i(go), .n_i(npul),
		.pin_o(pin), .busy_o(busy));
	// Clock
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	// Timer in timer mode on the bus clock; keeps running in sleep
	always @(posedge clk_i) begin
		tmr <= rst_i ? 16'h0000 : tmr + 16'h0001;
		tseen <= (trig === 1'b1) | (tseen & ~go);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		checked++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// Classic cycle: hold until ack is sampled, then release
	task automatic wb(input logic w, input logic [7:0] a, d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = rdo;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		if (ack !== 1'b1) fails++;
	endtask
	task automatic pulses(input logic [4:0] n);
		int k;
		k = 0;
		@(posedge clk_i);
		npul <= n;
		go <= 1;
		@(posedge clk_i);
		go <= 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (busy !== 1'b0 && k < 200);
		repeat (10) @(posedge clk_i);
	endtask
	task automatic mode_set(input logic [3:0] m);
		wb(1, OFS_CONTROL, 8'h00);
		wb(1, OFS_CONTROL, {4'h0, m});
		wb(1, OFS_STATUS, 8'h01);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			wb(0, 8'(i * 4), 8'h00);
			chk("reg_reset", 16'h0, rdat[15:0]);
		end
		wb(1, OFS_MATCH_LOW, 8'h5A);
		wb(0, OFS_MATCH_LOW, 8'h00);
		chk("match_rw", 16'h5A, rdat[15:0]);
	endtask
	// Captured value must come from the last qualified edge
	task automatic t_cap(input logic [3:0] m, input logic [4:0] pre, post);
		logic [15:0] v, t;
		mode_set(m);
		if (pre != 0) begin
			pulses(pre);
			chk("early_flag", 16'h0, {15'h0, irq});
		end
		pulses(post);
		t = tmr;
		chk("cap_flag", 16'h1, {15'h0, irq});
		wb(0, OFS_MATCH_LOW, 8'h00);
		v[7:0] = rdat[7:0];
		wb(0, OFS_MATCH_HIGH, 8'h00);
		v[15:8] = rdat[7:0];
		chk("cap_win", 16'h1, {15'h0, v <= t && v + 16'd13 >= t});
	endtask
	task automatic t_cmp(input logic [3:0] m, input logic pe, oe_e);
		logic [15:0] mv;
		int k;
		mode_set(m);
		mv = tmr + 16'd40;
		wb(1, OFS_MATCH_LOW, mv[7:0]);
		wb(1, OFS_MATCH_HIGH, mv[15:8]);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (irq !== 1'b1 && k < 100);
		@(posedge clk_i);
		chk("cmp_flag", 16'h1, {15'h0, irq});
		chk("cmp_pin", {15'h0, pe}, {15'h0, pin_o});
		chk("cmp_oe", {15'h0, oe_e}, {15'h0, oe});
		chk("cmp_trig", {15'h0, m == 4'hB}, {15'h0, tseen});
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		t_regs();
		t_cap(TCCU_CAP_FALL, 0, 1);
		t_cap(TCCU_CAP_RISE, 0, 2);
		t_cap(TCCU_CAP_RISE16, 15, 1);
		mode_set(TCCU_CAP_RISE4);
		pulses(2);
		t_cap(TCCU_CAP_RISE4, 2, 2);
		slp <= 1;
		t_cap(TCCU_CAP_RISE, 0, 1);
		slp <= 0;
		t_cmp(TCCU_CMP_TOGGLE, 1, 1);
		t_cmp(TCCU_CMP_SET, 1, 1);
		t_cmp(TCCU_CMP_CLEAR, 0, 1);
		t_cmp(TCCU_CMP_SWINT, 0, 0);
		t_cmp(TCCU_CMP_TRIG, 0, 0);
		rst_i <= 1;
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		t_regs();
		stop_test();
	end
endmodule
